// ### sim/smbme_assertions.sv
// Checker for the two-wire serial engine, bound to its top-level ports.
// Assumes a single clk domain and lines seen raw at the engine pins.
`timescale 1ns/1ps

module smbme_checker
	import smbme_pkg::*;
#(
	parameter int SCL_LOW_TO_CYC = SCL_LOW_TO_CYC_DEF
)
(
	// Clock, reset and controls
	input wire logic clk,
	input wire logic srst,
	input wire logic scl_low_timeout_enable,
	input wire logic mst_start,
	input wire logic sw_go,
	// Status
	input wire logic evt_valid,
	input wire logic is_master,
	input wire logic busy,
	input wire logic start_pending,
	input wire logic arb_lost,
	input wire logic scl_timeout,
	// Lines
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe
);
	int lo_n;
	int hi_n;
	int tl_n;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	// ********
	// Phase counters
	// ********
	// Raw lines lead the engine's synchroniser, so hi_n and tl_n are upper bounds; lo_n follows scl_oe
	always_ff @(posedge clk)
	begin
		lo_n <= (srst || !scl_oe) ? 0 : lo_n + 1;
		hi_n <= (srst || !scl_i || scl_oe) ? 0 : hi_n + 1;
		tl_n <= (srst || scl_i || !scl_low_timeout_enable) ? 0 : tl_n + 1;
	end

	sequence start_seen;
		scl_i && $fell(sda_i);
	endsequence

	sequence stop_seen;
		scl_i && $rose(sda_i);
	endsequence

	// ********
	// Properties
	// ********
	pull_only_a: assert property (!scl_o && !sda_o)
		else $error("pin output driven high");
	start_busy_a: assert property (start_seen |-> ##[1:5] busy)
		else $error("busy not set after start");
	stop_idle_a: assert property (stop_seen |-> ##[1:5] !busy)
		else $error("busy not cleared after stop");
	low_phase_a: assert property ($fell(scl_oe) && is_master |-> lo_n >= 10)
		else $error("clock low phase too short");
	high_phase_a: assert property ($rose(scl_oe) && is_master |-> hi_n >= 10)
		else $error("clock high phase too short");
	evt_ack_a: assert property (evt_valid && sw_go |=> !evt_valid)
		else $error("event not cleared by answer");
	hold_clock_a: assert property (evt_valid && is_master |=> scl_oe || !evt_valid)
		else $error("clock not held during event");
	pend_start_a: assert property (mst_start && busy |=> start_pending)
		else $error("start not deferred on busy bus");
	arb_lose_a: assert property ($rose(arb_lost) |->
		($past(is_master) && !$past(sda_oe)) ##[0:1] !is_master)
		else $error("bad arbitration loss");
	timeout_set_a: assert property (tl_n == SCL_LOW_TO_CYC + 6 |-> scl_timeout)
		else $error("clock low timeout missed");
	timeout_early_a: assert property ($rose(scl_timeout) |-> tl_n >= SCL_LOW_TO_CYC - 2)
		else $error("clock low timeout early");
endmodule : smbme_checker

// ### sim/smbme_slave_model.sv
// Slave device model on the two-wire bus: acks its address, takes writes,
// serves one read byte. Assumes the bench resolves lines with pull-ups.
`timescale 1ns/1ps

module smbme_slave_model
(
	// Clock and lines
	input  wire logic       clk,
	input  wire logic       scl,
	input  wire logic       sda,
	// Setup
	input  wire logic [6:0] addr,
	input  wire logic [7:0] rd_byte,
	input  wire logic [7:0] stretch,
	// Pulls and capture
	output logic            scl_oe,
	output logic            sda_oe,
	output logic [7:0]      last_rx
);
	logic [3:0] bit_n;
	logic [7:0] sh;
	logic       sel;
	logic       rd;
	logic       addr_ph;
	logic       in_frame;

	initial
		{scl_oe, sda_oe, sel, rd, addr_ph, in_frame, last_rx, bit_n, sh} = '0;

	always @(negedge sda)
		if (scl === 1'b1)
		begin
			{in_frame, addr_ph, sel} = 3'b110;
			bit_n = 4'hF;
		end

	always @(posedge sda)
		if (scl === 1'b1)
		begin
			{in_frame, sel} = 2'b00;
			sda_oe <= 1'b0;
		end

	always @(posedge scl)
		if (in_frame && bit_n < 4'h8)
			sh = {sh[6:0], sda};
		else if (in_frame && bit_n == 4'h8 && !addr_ph && rd && sda)
			sel = 1'b0;

	// Data moves 20 ns after the fall, a hold time the engine must tolerate
	always @(negedge scl)
		if (in_frame)
		begin
			if (bit_n == 4'h8)
				{bit_n, addr_ph} = 5'h00;
			else
				bit_n = bit_n + 4'h1;
			if (bit_n == 4'h8 && addr_ph)
			begin
				sel = (sh[7:1] == addr);
				rd = sh[0];
			end
			if (bit_n == 4'h8 && sel && !rd)
				last_rx = sh;
			if (bit_n == 4'h8)
				sda_oe <= #20 sel && (addr_ph || !rd);
			else
				sda_oe <= #20 sel && rd && !addr_ph && !rd_byte[3'h7 - bit_n[2:0]];
		end

	// Slow device: holds the clock low after each fall
	always @(negedge scl)
		if (in_frame && stretch != 8'h00)
		begin
			scl_oe = 1'b1;
			repeat (stretch) @(posedge clk);
			scl_oe = 1'b0;
		end
endmodule : smbme_slave_model

// ### sim/smbus_master_slave_engine_tb_top.sv
// Bench for the serial engine: master traffic against a slave model.
// Assumes pull-ups on both lines and a free-running bit-rate clock.
`timescale 1ns/1ps

bind smbme_engine smbme_checker #(.SCL_LOW_TO_CYC(SCL_LOW_TO_CYC)) u_chk (
	.clk(clk), .srst(srst), .scl_low_timeout_enable(scl_low_timeout_enable),
	.mst_start(mst_start), .sw_go(sw_go), .evt_valid(evt_valid), .is_master(is_master),
	.busy(busy), .start_pending(start_pending), .arb_lost(arb_lost),
	.scl_timeout(scl_timeout), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));

module smbus_master_slave_engine_tb_top
	import smbme_pkg::*;
;
	localparam int TO_CYC = 200;
	localparam logic [7:0] OWN_BYTE = 8'h66;
	logic clk = 1'b0;
	logic rate_clk = 1'b0;
	logic srst, to_en, ft_en, mst_start, sw_go, sw_ack, sw_stop, flag_clr;
	logic [7:0] mst_addr, sw_tx_byte, rx_byte, m_rx, stretch;
	logic [1:0] evt_code;
	logic evt_valid, rx_ack, is_master, tx_mode, busy, start_pending, arb_lost;
	logic scl_timeout, scl_o, scl_oe, sda_o, sda_oe, m_scl_oe, m_sda_oe, tb_scl_low, tb_sda_low;
	wire scl, sda;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;

	assign scl = !(scl_oe | m_scl_oe | tb_scl_low);
	assign sda = !(sda_oe | m_sda_oe | tb_sda_low);

	initial forever #2 clk = !clk;
	initial
	begin
		#7;
		forever #24 rate_clk = !rate_clk;
	end

	smbme_engine #(.SCL_LOW_TO_CYC(TO_CYC)) uut (
		.clk(clk), .srst(srst), .rate_clk(rate_clk), .enable(1'b1), .slave_inhibit(1'b0),
		.scl_low_timeout_enable(to_en), .bus_free_timeout_enable(ft_en),
		.own_addr(OWN_BYTE[7:1]),
		.mst_start(mst_start), .mst_addr(mst_addr), .sw_go(sw_go), .sw_tx_byte(sw_tx_byte),
		.sw_ack(sw_ack), .sw_stop(sw_stop), .flag_clr(flag_clr), .evt_valid(evt_valid),
		.evt_code(evt_code), .rx_byte(rx_byte), .rx_ack(rx_ack), .is_master(is_master),
		.tx_mode(tx_mode), .busy(busy), .start_pending(start_pending), .arb_lost(arb_lost),
		.scl_timeout(scl_timeout), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda),
		.sda_o(sda_o), .sda_oe(sda_oe));

	smbme_slave_model u_slave (
		.clk(clk), .scl(scl), .sda(sda), .addr(7'h50), .rd_byte(8'h96), .stretch(stretch),
		.scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .last_rx(m_rx));

	// ********
	// Checks and bus tasks
	// ********
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chkb(input logic got, input logic exp);
		chk({7'h00, got}, {7'h00, exp});
	endtask : chkb

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask : cycles

	task automatic req(input logic [7:0] a);
		@(negedge clk);
		mst_start = 1'b1;
		mst_addr = a;
		@(negedge clk);
		mst_start = 1'b0;
	endtask : req

	task automatic go(input logic [7:0] b, input logic a, input logic s);
		@(negedge clk);
		{sw_go, sw_tx_byte, sw_ack, sw_stop} = {1'b1, b, a, s};
		@(negedge clk);
		{sw_go, sw_stop} = 2'b00;
	endtask : go

	task automatic wait_evt(input logic [1:0] code);
		for (int n = 0; n < 3000 && evt_valid !== 1'b1; n++)
			@(negedge clk);
		chk({evt_valid, 5'h00, evt_code}, {1'b1, 5'h00, code});
	endtask : wait_evt

	// One bit as a bench master: pull SCL, set SDA while low, release SCL
	task automatic bb_bit(input logic b);
		tb_scl_low = 1'b1;
		cycles(8);
		tb_sda_low = !b;
		cycles(8);
		tb_scl_low = 1'b0;
		cycles(16);
	endtask : bb_bit

	task automatic wait_idle();
		for (int n = 0; n < 3000 && busy !== 1'b0; n++)
			@(negedge clk);
		chkb(busy, 1'b0);
	endtask : wait_idle

	// Hang guard: the sequence needs well under this many cycles
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			err_total++;
			print_verdict();
		end
	end

	// ********
	// Sequence
	// ********
	initial
	begin
		{srst, to_en, ft_en, mst_start, sw_go, sw_ack, sw_stop, flag_clr} = 8'h80;
		{mst_addr, sw_tx_byte, stretch, tb_scl_low, tb_sda_low} = '0;
		cycles(10);
		srst = 1'b0;
		cycles(5);
		stretch = 8'h1E;
		req(8'hA0);
		wait_evt(EVT_TX_DONE);
		chkb(rx_ack, 1'b1);
		chkb(is_master, 1'b1);
		chkb(tx_mode, 1'b1);
		go(8'h5C, 1'b0, 1'b0);
		wait_evt(EVT_TX_DONE);
		go(8'h00, 1'b0, 1'b1);
		wait_idle();
		chk(m_rx, 8'h5C);
		$display("write done");
		stretch = 8'h00;
		req(8'h22);
		wait_evt(EVT_TX_DONE);
		chkb(rx_ack, 1'b0);
		go(8'h00, 1'b0, 1'b1);
		wait_idle();
		req(8'hA1);
		wait_evt(EVT_TX_DONE);
		chkb(tx_mode, 1'b0);
		go(8'h00, 1'b0, 1'b0);
		wait_evt(EVT_RX_BYTE);
		chk(rx_byte, 8'h96);
		go(8'h00, 1'b0, 1'b1);
		wait_idle();
		$display("nack and read done");
		tb_sda_low = 1'b1;
		cycles(20);
		chkb(busy, 1'b1);
		tb_scl_low = 1'b1;
		cycles(20);
		tb_sda_low = 1'b0;
		cycles(20);
		tb_scl_low = 1'b0;
		req(8'hA0);
		cycles(300);
		chkb(start_pending, 1'b1);
		ft_en = 1'b1;
		wait_evt(EVT_TX_DONE);
		go(8'h00, 1'b0, 1'b1);
		wait_idle();
		$display("free timeout done");
		for (int e = 0; e < 2; e++)
		begin
			to_en = e[0];
			tb_scl_low = 1'b1;
			cycles(TO_CYC + 20);
			tb_scl_low = 1'b0;
			cycles(5);
			chkb(scl_timeout, e[0]);
			flag_clr = 1'b1;
			cycles(1);
			flag_clr = 1'b0;
			chkb(scl_timeout, 1'b0);
		end
		$display("low timeout done");
		req(8'hFE);
		for (int n = 0; n < 500 && scl !== 1'b0; n++)
			@(negedge clk);
		tb_sda_low = 1'b1;
		cycles(200);
		chkb(arb_lost, 1'b1);
		chkb(is_master, 1'b0);
		// Bench won with a zero and finishes the engine's own address
		for (int i = 6; i >= 0; i--)
			bb_bit(OWN_BYTE[i]);
		tb_scl_low = 1'b1;
		cycles(8);
		tb_sda_low = 1'b0;
		wait_evt(EVT_SLV_ADDR);
		chk(rx_byte, OWN_BYTE);
		chkb(tx_mode, 1'b0);
		go(8'h00, 1'b1, 1'b0);
		cycles(6);
		chkb(sda_oe, 1'b1);
		tb_scl_low = 1'b0;
		cycles(16);
		bb_bit(1'b0);
		tb_sda_low = 1'b0;
		wait_idle();
		wait_evt(EVT_SLV_STOP);
		flag_clr = 1'b1;
		cycles(1);
		flag_clr = 1'b0;
		chkb(arb_lost, 1'b0);
		$display("arbitration done");
		print_verdict();
	end
endmodule : smbus_master_slave_engine_tb_top

// ### verilog/smbme_engine.sv
// Two-wire master/slave byte engine with arbitration, clock stretching and timeouts.
// Assumes open-drain pads resolved outside and a free-running bit-rate tick clock.
//
// Notes on behaviour
// - Bit rate never above clk/20
// - Software moves bytes; hardware sequences bits
// - START, address plus direction, data, STOP
// - Direction bit one reads, zero writes
// - Receiver acks by holding SDA low
// - Master originates transfers and drives clock
// - Master writer waits for ack each byte
// - Slave sends read bytes; master acks
// - Master issues STOP after last byte
// - Sender drives data, receiver drives ack
// - Whoever sends START becomes the master
// - Start master only on free bus
// - Lost data-bit compare turns master into slave
// - Winner continues without any interruption
// - Wait for SCL release before high timing
// - SCL low 25 ms: timeout, reset fast
// - Low timer reloads high, counts low
// - Free after ten idle tick periods
// - Pending START fires after free timeout
// - Free detection needs running tick clock
// - Long idle high lines mean free bus
// - Only pull lines low or release
// - Busy set in transfer, cleared by STOP/free
`timescale 1ns/1ps

module smbme_engine
	import smbme_pkg::*;
#(
	parameter int SCL_LOW_TO_CYC = SCL_LOW_TO_CYC_DEF
)
(
	// Clocks and reset
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       rate_clk,
	// Configuration
	input  wire logic       enable,
	input  wire logic       slave_inhibit,
	input  wire logic       scl_low_timeout_enable,
	input  wire logic       bus_free_timeout_enable,
	input  wire logic [6:0] own_addr,
	// Master request
	input  wire logic       mst_start,
	input  wire logic [7:0] mst_addr,
	// Software byte handshake
	input  wire logic       sw_go,
	input  wire logic [7:0] sw_tx_byte,
	input  wire logic       sw_ack,
	input  wire logic       sw_stop,
	input  wire logic       flag_clr,
	// Status
	output logic            evt_valid,
	output logic [1:0]      evt_code,
	output logic [7:0]      rx_byte,
	output logic            rx_ack,
	output logic            is_master,
	output logic            tx_mode,
	output logic            busy,
	output logic            start_pending,
	output logic            arb_lost,
	output logic            scl_timeout,
	// Bus pins
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe
);

	// ****************************************
	// Declarations
	// ****************************************
	smbme_state_t state_q;
	logic        rrst_m_q, rrst_s_q, tog_r_q;
	logic        tog_m_q, tog_s_q, tog_p_q, tick;
	logic        scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	logic        scl_rise, scl_fall, start_det, stop_det;
	logic [23:0] tout_cnt_q;
	logic        tout_hit, abort;
	logic [3:0]  free_cnt_q;
	logic        free_hit;
	logic        busy_q, arb_q, tout_q, line_lo_q;
	logic        master_q, tx_q, addr_ph_q, skip_q, stop_pend_q, ack_out_q, rx_ack_q;
	logic        start_pend_q, evt_valid_q, go_q;
	logic [1:0]  evt_code_q;
	logic [3:0]  bit_q;
	logic [7:0]  shift_q, txd_q, maddr_q, rx_byte_q;
	logic        phase_hi_q, scl_oe_q, sda_oe_q;
	logic [3:0]  ph_cyc_q;
	logic [1:0]  ph_tick_q;
	logic        cnt_en, lo_done, hi_done, arb_hit, addr_match;
	logic [1:0]  hold_q;
	logic        upd, drive_low;

	// ****************************************
	// Bit-rate tick domain
	// ****************************************
	// One toggle per overflow; clk domain turns each change into a tick
	always_ff @(posedge rate_clk)
	begin
		rrst_m_q <= srst;
		rrst_s_q <= rrst_m_q;
	end

	always_ff @(posedge rate_clk)
	begin
		if (rrst_s_q)
			tog_r_q <= 1'b0;
		else
			tog_r_q <= ~tog_r_q;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			tog_m_q <= 1'b0;
			tog_s_q <= 1'b0;
			tog_p_q <= 1'b0;
		end
		else
		begin
			tog_m_q <= tog_r_q;
			tog_s_q <= tog_m_q;
			tog_p_q <= tog_s_q;
		end
	end

	assign tick = tog_s_q ^ tog_p_q;

	// ****************************************
	// Line sampling and condition detection
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			{scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
			{sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
		end
		else
		begin
			{scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
			{sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
		end
	end

	assign scl_rise  = scl_s_q & ~scl_p_q;
	assign scl_fall  = ~scl_s_q & scl_p_q;
	assign start_det = enable & scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign stop_det  = enable & scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

	// ****************************************
	// Timeouts and bus state
	// ****************************************
	// Reload while SCL high, count while low; reset happens at once, well inside 10 ms
	always_ff @(posedge clk)
	begin
		if (srst || !scl_low_timeout_enable || !enable || scl_s_q)
			tout_cnt_q <= 24'h000000;
		else if (tout_cnt_q != SCL_LOW_TO_CYC[23:0])
			tout_cnt_q <= tout_cnt_q + 24'h000001;
	end

	assign tout_hit = scl_low_timeout_enable & enable & ~scl_s_q
		& (tout_cnt_q == 24'(SCL_LOW_TO_CYC - 1));
	assign abort    = ~enable | tout_hit;

	// Free detection only advances on ticks, so the timer must keep running
	always_ff @(posedge clk)
	begin
		if (srst || !bus_free_timeout_enable || !busy_q || !scl_s_q || !sda_s_q)
			free_cnt_q <= 4'h0;
		else if (tick && free_cnt_q != FREE_TICKS)
			free_cnt_q <= free_cnt_q + 4'h1;
	end

	// Strictly more than ten idle periods; a tick rate that gives 50 us idle meets the bus rule
	assign free_hit = bus_free_timeout_enable & busy_q & scl_s_q & sda_s_q & tick
		& (free_cnt_q == FREE_TICKS);

	always_ff @(posedge clk)
	begin
		if (srst || !enable)
			busy_q <= 1'b0;
		else if (stop_det || free_hit)
			busy_q <= 1'b0;
		else if (start_det)
			busy_q <= 1'b1;
	end

	// ****************************************
	// Sticky status flags
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			arb_q  <= 1'b0;
			tout_q <= 1'b0;
		end
		else
		begin
			if (flag_clr)
			begin
				arb_q  <= 1'b0;
				tout_q <= 1'b0;
			end
			if (arb_hit)
				arb_q <= 1'b1;
			if (tout_hit)
				tout_q <= 1'b1;
		end
	end

	// ****************************************
	// Byte and bit sequencer
	// ****************************************
	assign cnt_en     = ~phase_hi_q | scl_s_q;
	assign lo_done    = (ph_tick_q >= LO_TICKS) && (ph_cyc_q >= MIN_PHASE_CYC);
	assign hi_done    = (ph_tick_q >= HI_TICKS) && (ph_cyc_q >= MIN_PHASE_CYC);
	assign arb_hit    = (state_q == ST_RUN) && master_q && tx_q && !bit_q[3] && shift_q[7]
		&& scl_rise && !skip_q && !sda_s_q;
	assign addr_match = (shift_q[7:1] == own_addr) && !slave_inhibit;

	always_ff @(posedge clk)
	begin
		if (srst || abort)
		begin
			state_q     <= ST_IDLE;
			master_q    <= 1'b0;
			tx_q        <= 1'b0;
			addr_ph_q   <= 1'b0;
			skip_q      <= 1'b0;
			stop_pend_q <= 1'b0;
			ack_out_q   <= 1'b0;
			rx_ack_q    <= 1'b0;
			bit_q       <= 4'h0;
			shift_q     <= 8'h00;
			txd_q       <= 8'h00;
			rx_byte_q   <= 8'h00;
			phase_hi_q  <= 1'b0;
			scl_oe_q    <= 1'b0;
			ph_cyc_q    <= 4'h0;
			ph_tick_q   <= 2'h0;
			evt_valid_q <= 1'b0;
			evt_code_q  <= EVT_TX_DONE;
			start_pend_q <= 1'b0;
			maddr_q     <= 8'h00;
		end
		else
		begin
			if (cnt_en && ph_cyc_q != MIN_PHASE_CYC)
				ph_cyc_q <= ph_cyc_q + 4'h1;
			if (cnt_en && tick && ph_tick_q != HI_TICKS)
				ph_tick_q <= ph_tick_q + 2'h1;
			if (sw_go)
				evt_valid_q <= 1'b0;
			case (state_q)
				ST_IDLE:
				begin
					// Bus free: no START seen since the last STOP or free timeout
					if (start_pend_q && !busy_q && scl_s_q && sda_s_q)
					begin
						state_q      <= ST_START;
						start_pend_q <= 1'b0;
						phase_hi_q   <= 1'b1;
						ph_cyc_q     <= 4'h0;
						ph_tick_q    <= 2'h0;
					end
				end
				ST_START:
				begin
					if (hi_done)
					begin
						state_q    <= ST_RUN;
						master_q   <= 1'b1;
						tx_q       <= 1'b1;
						addr_ph_q  <= 1'b1;
						bit_q      <= 4'h0;
						shift_q    <= maddr_q;
						scl_oe_q   <= 1'b1;
						phase_hi_q <= 1'b0;
						ph_cyc_q   <= 4'h0;
						ph_tick_q  <= 2'h0;
					end
				end
				ST_RUN:
				begin
					if (master_q)
					begin
						if (!phase_hi_q && lo_done)
						begin
							scl_oe_q   <= 1'b0;
							phase_hi_q <= 1'b1;
							ph_cyc_q   <= 4'h0;
							ph_tick_q  <= 2'h0;
						end
						else if (phase_hi_q && (hi_done || scl_fall))
						begin
							scl_oe_q   <= 1'b1;
							phase_hi_q <= 1'b0;
							ph_cyc_q   <= 4'h0;
							ph_tick_q  <= 2'h0;
						end
					end
					if (scl_rise && !skip_q)
					begin
						if (!bit_q[3])
							shift_q <= {shift_q[6:0], sda_s_q};
						else
							rx_ack_q <= ~sda_s_q;
						if (arb_hit)
						begin
							master_q <= 1'b0;
							tx_q     <= 1'b0;
							scl_oe_q <= 1'b0;
						end
					end
					if (scl_fall && skip_q)
						skip_q <= 1'b0;
					else if (scl_fall)
					begin
						if (bit_q < LAST_BIT)
							bit_q <= bit_q + 4'h1;
						else if (bit_q == LAST_BIT)
						begin
							bit_q <= ACK_BIT;
							// Receivers stop before the ack so software picks it
							if (!tx_q && addr_ph_q && !master_q && !addr_match)
								state_q <= ST_IDLE;
							else if (!tx_q)
							begin
								state_q     <= ST_WAIT;
								evt_valid_q <= 1'b1;
								evt_code_q  <= addr_ph_q ? EVT_SLV_ADDR : EVT_RX_BYTE;
								rx_byte_q   <= shift_q;
								scl_oe_q    <= 1'b1;
							end
						end
						else
						begin
							bit_q <= 4'h0;
							if (addr_ph_q)
							begin
								addr_ph_q <= 1'b0;
								tx_q      <= master_q ? ~shift_q[0] : shift_q[0];
							end
							if (tx_q && (master_q || rx_ack_q))
							begin
								state_q     <= ST_WAIT;
								evt_valid_q <= 1'b1;
								evt_code_q  <= EVT_TX_DONE;
								scl_oe_q    <= 1'b1;
							end
							else if (tx_q)
								state_q <= ST_IDLE;
							else if (master_q && stop_pend_q)
							begin
								state_q   <= ST_STOP_LO;
								ph_cyc_q  <= 4'h0;
								ph_tick_q <= 2'h0;
							end
							else if (!master_q && addr_ph_q && shift_q[0])
								shift_q <= txd_q;
						end
					end
				end
				ST_WAIT:
				begin
					if (sw_go)
					begin
						ack_out_q   <= sw_ack;
						stop_pend_q <= sw_stop & master_q;
						txd_q       <= sw_tx_byte;
						if (bit_q == 4'h0 && tx_q)
							shift_q <= sw_tx_byte;
						ph_cyc_q   <= 4'h0;
						ph_tick_q  <= 2'h0;
						phase_hi_q <= 1'b0;
						if (master_q && sw_stop && bit_q == 4'h0)
							state_q <= ST_STOP_LO;
						else
							state_q <= ST_RUN;
						if (!master_q)
							scl_oe_q <= 1'b0;
					end
				end
				ST_STOP_LO:
				begin
					if (lo_done)
					begin
						state_q    <= ST_STOP_HI;
						scl_oe_q   <= 1'b0;
						phase_hi_q <= 1'b1;
						ph_cyc_q   <= 4'h0;
						ph_tick_q  <= 2'h0;
					end
				end
				ST_STOP_HI:
				begin
					if (hi_done)
					begin
						state_q     <= ST_IDLE;
						master_q    <= 1'b0;
						stop_pend_q <= 1'b0;
					end
				end
				default:
					state_q <= ST_IDLE;
			endcase
			// A START seen outside ST_START restarts address reception; after any START the next fall is framing
			if (start_det)
				skip_q <= 1'b1;
			if (start_det && state_q != ST_START)
			begin
				state_q   <= ST_RUN;
				master_q  <= 1'b0;
				tx_q      <= 1'b0;
				addr_ph_q <= 1'b1;
				bit_q     <= 4'h0;
				scl_oe_q  <= 1'b0;
			end
			if (stop_det && state_q != ST_STOP_HI)
			begin
				state_q  <= ST_IDLE;
				master_q <= 1'b0;
				scl_oe_q <= 1'b0;
				if (state_q != ST_IDLE && !master_q)
				begin
					evt_valid_q <= 1'b1;
					evt_code_q  <= EVT_SLV_STOP;
				end
			end
			// Free timeout also ends a half-seen frame, so a pending START can go at once
			if (free_hit)
			begin
				state_q  <= ST_IDLE;
				master_q <= 1'b0;
				scl_oe_q <= 1'b0;
			end
			if (mst_start)
			begin
				start_pend_q <= 1'b1;
				maddr_q      <= mst_addr;
			end
		end
	end

	// ****************************************
	// Data line drive
	// ****************************************
	// Changes wait out a hold time after SCL falls so they never look like START/STOP
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			hold_q <= 2'h0;
			go_q   <= 1'b0;
		end
		else
		begin
			go_q <= (state_q == ST_WAIT) && sw_go;
			if (scl_fall)
				hold_q <= HOLD_CYC;
			else if (hold_q != 2'h0)
				hold_q <= hold_q - 2'h1;
		end
	end

	always_comb
	begin
		case (state_q)
			ST_START, ST_STOP_LO, ST_STOP_HI:
				drive_low = 1'b1;
			ST_RUN:
				drive_low = bit_q[3] ? (~tx_q & ack_out_q) : (tx_q & ~shift_q[7]);
			default:
				drive_low = 1'b0;
		endcase
	end

	assign upd = (hold_q == 2'h1) || go_q
		|| ((state_q == ST_START || state_q == ST_STOP_LO) && hold_q == 2'h0);

	always_ff @(posedge clk)
	begin
		if (srst || abort)
			sda_oe_q <= 1'b0;
		else if (state_q == ST_STOP_HI && hi_done)
			sda_oe_q <= 1'b0;
		else if (upd)
			sda_oe_q <= drive_low;
	end

	// Pins only ever pull low; the pull-up makes the high level
	always_ff @(posedge clk)
	begin
		line_lo_q <= 1'b0;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign scl_o         = line_lo_q;
	assign sda_o         = line_lo_q;
	assign scl_oe        = scl_oe_q;
	assign sda_oe        = sda_oe_q;
	assign evt_valid     = evt_valid_q;
	assign evt_code      = evt_code_q;
	assign rx_byte       = rx_byte_q;
	assign rx_ack        = rx_ack_q;
	assign is_master     = master_q;
	assign tx_mode       = tx_q;
	assign busy          = busy_q;
	assign start_pending = start_pend_q;
	assign arb_lost      = arb_q;
	assign scl_timeout   = tout_q;

endmodule : smbme_engine

// ### verilog/smbme_pkg.sv
// Shared constants of the two-wire serial engine: states, event codes, timing.
// Assumes a 250 MHz system clock and a bit-rate tick clock from a running timer.
package smbme_pkg;

	// ****************************************
	// Clock and protocol timing
	// ****************************************
	localparam int CLK_FREQ_KHZ        = 250000;
	localparam int SCL_LOW_TO_MS       = 25;
	localparam int SCL_LOW_TO_CYC_DEF  = SCL_LOW_TO_MS * CLK_FREQ_KHZ;
	localparam int RESET_WITHIN_MS     = 10;
	localparam int BUS_IDLE_US         = 50;
	localparam int BUS_IDLE_CYC        = (BUS_IDLE_US * CLK_FREQ_KHZ) / 1000;
	// Ten system clocks per SCL phase keeps the bit rate at or below 1/20 clk
	localparam logic [3:0] MIN_PHASE_CYC = 4'hA;
	localparam logic [1:0] LO_TICKS      = 2'h1;
	localparam logic [1:0] HI_TICKS      = 2'h2;
	localparam logic [3:0] FREE_TICKS    = 4'hA;
	localparam logic [1:0] HOLD_CYC      = 2'h3;
	localparam logic [3:0] ACK_BIT       = 4'h8;
	localparam logic [3:0] LAST_BIT      = 4'h7;

	// ****************************************
	// Software event codes
	// ****************************************
	localparam logic [1:0] EVT_TX_DONE  = 2'h0;
	localparam logic [1:0] EVT_RX_BYTE  = 2'h1;
	localparam logic [1:0] EVT_SLV_ADDR = 2'h2;
	localparam logic [1:0] EVT_SLV_STOP = 2'h3;

	// ****************************************
	// Engine states
	// ****************************************
	typedef enum logic [5:0] {
		ST_IDLE    = 6'h01,
		ST_START   = 6'h02,
		ST_RUN     = 6'h04,
		ST_WAIT    = 6'h08,
		ST_STOP_LO = 6'h10,
		ST_STOP_HI = 6'h20
	} smbme_state_t;

endpackage : smbme_pkg
